//--- rtl/ccd_pkg.sv
`default_nettype none
package ccd_pkg;
  // Widths
  localparam int DATA_W  = 8;
  localparam int INSTR_W = 14;
  localparam int IDX_W   = 7;
  localparam int ADDR_W  = 8;
  localparam int FILE_N  = 128;
  // Instruction encodings
  localparam logic [13:0] OP_CLEAR_WORKING = 14'h0103;
  localparam logic [13:0] OP_WATCHDOG_KICK = 14'h0064;
  localparam logic [5:0]  OP_COMPLEMENT    = 6'h09;
  localparam logic [5:0]  OP_DECREMENT     = 6'h03;
  localparam int          OP_LSB           = 8;
  localparam int          DEST_BIT         = 7;
  // Register port map
  localparam logic [7:0] ADDR_ACCUM  = 8'h80;
  localparam logic [7:0] ADDR_STATUS = 8'h81;
  localparam logic [7:0] ADDR_WDOG   = 8'h82;
  localparam logic [7:0] ADDR_PRESC  = 8'h83;
  localparam int         ADDR_FILE_BIT = 7;
  // Status field positions
  localparam int ST_NULL_BIT   = 0;
  localparam int ST_SLEEP_BIT  = 1;
  localparam int ST_EXPIRY_BIT = 2;
  // Watchdog wrap points
  localparam logic [7:0] PRESC_LAST = 8'hff;
  localparam logic [7:0] WDOG_LAST  = 8'hff;

  // Instruction request
  typedef struct packed {
    logic        valid;
    logic [13:0] word;
  } ccd_instr_t;

  // Status flags
  typedef struct packed {
    logic expiry_n;
    logic sleep_n;
    logic result_null;
  } ccd_flags_t;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccd_bus_t;

  // Whole block state
  typedef struct packed {
    logic [127:0][7:0] file;
    logic [7:0]        accum;
    ccd_flags_t        flags;
    logic [7:0]        wdog;
    logic [7:0]        presc;
    logic [7:0]        rdata;
    logic              done;
    logic              unknown;
  } ccd_state_t;

  // Reset values
  localparam ccd_flags_t FLAGS_RST = '{expiry_n: 1'b1, sleep_n: 1'b1,
                                       result_null: 1'b0};
  localparam ccd_state_t STATE_RST = '{file: '0, accum: 8'h00,
                                       flags: FLAGS_RST, wdog: 8'h00,
                                       presc: 8'h00, rdata: 8'h00,
                                       done: 1'b0, unknown: 1'b0};
endpackage
`default_nettype wire

//--- rtl/ccd_core.sv
// The placing of the registers and strobed register access were chosen for this implementation.
`default_nettype none
module ccd_core (
  // Clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  // Instruction port
  input  wire ccd_pkg::ccd_instr_t instr_i,
  // Register port
  input  wire ccd_pkg::ccd_bus_t   bus_i,
  output var  logic [7:0]         rdata_o,
  // Core state
  output var  logic [7:0]         accumulator_o,
  output var  ccd_pkg::ccd_flags_t flags_o,
  output var  logic [7:0]         watchdog_count_o,
  output var  logic               exec_done_o,
  output var  logic               exec_unknown_o
);
  import ccd_pkg::*;

  ccd_state_t       st_ff;
  ccd_state_t       nxt_st;
  logic [6:0]       idx_c;
  logic             dest_c;
  logic [7:0]       operand_c;
  logic [7:0]       result_c;
  logic             is_clear_working_c;
  logic             is_kick_c;
  logic             is_comp_c;
  logic             is_dec_c;

  // Instruction field decode
  assign idx_c     = instr_i.word[IDX_W-1:0];
  assign dest_c    = instr_i.word[DEST_BIT];
  assign operand_c = st_ff.file[idx_c];
  assign is_clear_working_c = instr_i.valid && instr_i.word == OP_CLEAR_WORKING;
  assign is_kick_c = instr_i.valid && instr_i.word == OP_WATCHDOG_KICK;
  assign is_comp_c = instr_i.valid &&
                     instr_i.word[INSTR_W-1:OP_LSB] == OP_COMPLEMENT;
  assign is_dec_c  = instr_i.valid &&
                     instr_i.word[INSTR_W-1:OP_LSB] == OP_DECREMENT;

  // Next state: watchdog, register port, then instruction (wins)
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.done    = 1'b0;
    nxt_st.unknown = 1'b0;
    nxt_st.rdata   = 8'h00;
    result_c       = 8'h00;
    // Free-running prescaler feeds the watchdog counter
    if (st_ff.presc == PRESC_LAST) begin
      nxt_st.presc = 8'h00;
      nxt_st.wdog  = st_ff.wdog + 8'h01;
      if (st_ff.wdog == WDOG_LAST) begin
        nxt_st.flags.expiry_n = 1'b0;
      end
    end else begin
      nxt_st.presc = st_ff.presc + 8'h01;
    end
    // Register port write
    if (bus_i.wr) begin
      if (!bus_i.addr[ADDR_FILE_BIT]) begin
        nxt_st.file[bus_i.addr[IDX_W-1:0]] = bus_i.wdata;
      end else if (bus_i.addr == ADDR_ACCUM) begin
        nxt_st.accum = bus_i.wdata;
      end else if (bus_i.addr == ADDR_STATUS) begin
        nxt_st.flags.result_null = bus_i.wdata[ST_NULL_BIT];
        nxt_st.flags.sleep_n     = bus_i.wdata[ST_SLEEP_BIT];
        nxt_st.flags.expiry_n    = bus_i.wdata[ST_EXPIRY_BIT];
      end
    end
    // Register port read, data in the next cycle
    if (bus_i.rd) begin
      if (!bus_i.addr[ADDR_FILE_BIT]) begin
        nxt_st.rdata = st_ff.file[bus_i.addr[IDX_W-1:0]];
      end else if (bus_i.addr == ADDR_ACCUM) begin
        nxt_st.rdata = st_ff.accum;
      end else if (bus_i.addr == ADDR_STATUS) begin
        nxt_st.rdata[ST_NULL_BIT]   = st_ff.flags.result_null;
        nxt_st.rdata[ST_SLEEP_BIT]  = st_ff.flags.sleep_n;
        nxt_st.rdata[ST_EXPIRY_BIT] = st_ff.flags.expiry_n;
      end else if (bus_i.addr == ADDR_WDOG) begin
        nxt_st.rdata = st_ff.wdog;
      end else if (bus_i.addr == ADDR_PRESC) begin
        nxt_st.rdata = st_ff.presc;
      end
    end
    // Instruction execution, single cycle
    if (is_clear_working_c) begin
      nxt_st.accum             = 8'h00;
      nxt_st.flags.result_null = 1'b1;
      nxt_st.done              = 1'b1;
    end else if (is_kick_c) begin
      nxt_st.wdog           = 8'h00;
      nxt_st.presc          = 8'h00;
      nxt_st.flags.expiry_n = 1'b1;
      nxt_st.flags.sleep_n  = 1'b1;
      nxt_st.done           = 1'b1;
    end else if (is_comp_c || is_dec_c) begin
      if (is_comp_c) begin
        result_c = ~operand_c;
      end else begin
        result_c = operand_c - 8'h01;
      end
      nxt_st.flags.result_null = (result_c == 8'h00);
      if (dest_c) begin
        nxt_st.file[idx_c] = result_c;
      end else begin
        nxt_st.accum = result_c;
      end
      nxt_st.done = 1'b1;
    end else if (instr_i.valid) begin
      nxt_st.unknown = 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_ff <= STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from state flops
  assign rdata_o          = st_ff.rdata;
  assign accumulator_o    = st_ff.accum;
  assign flags_o          = st_ff.flags;
  assign watchdog_count_o = st_ff.wdog;
  assign exec_done_o      = st_ff.done;
  assign exec_unknown_o   = st_ff.unknown;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  chk_clear_working: assert property (
    is_clear_working_c |=> accumulator_o == 8'h00 && flags_o.result_null
                  && exec_done_o)
    else $error("clear_working did not clear accumulator");
  chk_comp_value: assert property (
    is_comp_c && !dest_c |=> accumulator_o == ~$past(operand_c))
    else $error("complement result wrong");
  chk_comp_target: assert property (
    is_comp_c && dest_c |=> accumulator_o == $past(accumulator_o)
                            && st_ff.file[$past(idx_c)] ==
                               ~$past(operand_c))
    else $error("complement went to wrong target");
  chk_kick_count: assert property (
    is_kick_c |=> watchdog_count_o == 8'h00 && st_ff.presc == 8'h00
                  ##1 watchdog_count_o == 8'h00)
    else $error("watchdog_kick did not clear watchdog");
  chk_kick_flags: assert property (
    is_kick_c |=> flags_o.expiry_n && flags_o.sleep_n &&
                  flags_o.result_null == $past(flags_o.result_null))
    else $error("watchdog_kick flags wrong");
  chk_dec_value: assert property (
    is_dec_c && !dest_c |=> accumulator_o == $past(operand_c) - 8'h01)
    else $error("decrement result wrong");
  chk_null_flag: assert property (
    is_dec_c |=> flags_o.result_null == ($past(operand_c) == 8'h01))
    else $error("null flag wrong after decrement");


  // Complement: null flag, done pulse, untouched source
  chk_comp_null: assert property (
    is_comp_c |=> flags_o.result_null == (~$past(operand_c) == 8'h00))
    else $error("null flag wrong after complement");
  chk_comp_done: assert property (
    is_comp_c |=> exec_done_o && !exec_unknown_o)
    else $error("complement did not pulse done");
  chk_comp_src_kept: assert property (
    is_comp_c && !dest_c && !bus_i.wr |=>
      st_ff.file[$past(idx_c)] == $past(operand_c))
    else $error("complement to accumulator touched source");

  // Decrement: file target, accumulator kept, done pulse
  chk_dec_file: assert property (
    is_dec_c && dest_c |=>
      st_ff.file[$past(idx_c)] == $past(operand_c) - 8'h01)
    else $error("decrement to file wrong");
  chk_dec_acc_kept: assert property (
    is_dec_c && dest_c && !bus_i.wr |=>
      accumulator_o == $past(accumulator_o))
    else $error("decrement to file touched accumulator");
  chk_dec_done: assert property (
    is_dec_c |=> exec_done_o && !exec_unknown_o)
    else $error("decrement did not pulse done");

  // Clear and kick: done pulses, and kick leaves the accumulator untouched
  chk_clear_done: assert property (
    is_clear_working_c |=> exec_done_o && !exec_unknown_o)
    else $error("clear_working did not pulse done");
  chk_kick_done: assert property (
    is_kick_c |=> exec_done_o && !exec_unknown_o)
    else $error("watchdog_kick did not pulse done");
  chk_kick_acc_kept: assert property (
    is_kick_c && !bus_i.wr |=> $stable(accumulator_o))
    else $error("watchdog_kick touched accumulator");

  // Unknown words and idle cycles
  chk_unknown_pulse: assert property (
    instr_i.valid && !(is_clear_working_c || is_kick_c || is_comp_c || is_dec_c)
      |=> exec_unknown_o && !exec_done_o)
    else $error("unknown word not flagged");
  chk_idle_quiet: assert property (
    !instr_i.valid |=> !exec_done_o && !exec_unknown_o)
    else $error("pulse without instruction");

  // Register port read data stands one cycle only
  chk_read_idle: assert property (
    !bus_i.rd |=> rdata_o == 8'h00)
    else $error("read data not cleared");
  chk_read_accum: assert property (
    bus_i.rd && bus_i.addr == ADDR_ACCUM |=>
      rdata_o == $past(accumulator_o))
    else $error("accumulator read wrong");
  chk_read_wdog: assert property (
    bus_i.rd && bus_i.addr == ADDR_WDOG |=>
      rdata_o == $past(watchdog_count_o))
    else $error("watchdog read wrong");

  // Watchdog counter advances only on prescaler wrap
  chk_wdog_tick: assert property (
    st_ff.presc == PRESC_LAST && !is_kick_c |=>
      watchdog_count_o == $past(watchdog_count_o) + 8'h01)
    else $error("watchdog did not advance");
  chk_wdog_hold: assert property (
    st_ff.presc != PRESC_LAST && !is_kick_c |=>
      $stable(watchdog_count_o))
    else $error("watchdog moved without tick");

  // Main scenarios
  cov_dec_wrap: cover property (is_dec_c && operand_c == 8'h00);
  cov_comp_file: cover property (is_comp_c && dest_c);
  cov_kick_expired: cover property (is_kick_c && !flags_o.expiry_n);
  cov_dec_file: cover property (is_dec_c && dest_c);
  cov_clear_run: cover property (is_clear_working_c ##1 is_dec_c);
endmodule // ccd_core
`default_nettype wire

//--- bench/ccd_core_tb.sv
`default_nettype none
module ccd_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ccd_pkg::*;
  // Stimulus and observed ports
  logic       mclk_i = 1'b0;
  logic       rst_i  = 1'b1;
  ccd_instr_t instr_i = '0;
  ccd_bus_t   bus_i   = '0;
  logic [7:0] rdata_o, accumulator_o, watchdog_count_o, rv;
  ccd_flags_t flags_o;
  logic       exec_done_o, exec_unknown_o;
  int         err_count = 0;
  int         n_compared = 0;
  // Clock, 4 ns period
  always #2 mclk_i = ~mclk_i;
  ccd_core u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .accumulator_o(accumulator_o),
    .flags_o(flags_o), .watchdog_count_o(watchdog_count_o),
    .exec_done_o(exec_done_o), .exec_unknown_o(exec_unknown_o));
  // Value compare
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // One instruction, results settled on return
  task automatic exec(input logic [13:0] w);
    @(posedge mclk_i);
    instr_i <= '{valid: 1'b1, word: w};
    @(posedge mclk_i);
    instr_i <= '0;
    #1;
  endtask
  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk_i);
    bus_i <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk_i);
    bus_i <= '0;
    #1;
    d = rdata_o;
  endtask
  // Complement to accumulator and back into a file register
  task automatic t_complement;
    wr(8'h05, 8'h13);
    exec({OP_COMPLEMENT, 1'b0, 7'd5});
    chk("complement_file acc", 8'hec, accumulator_o);
    chk("complement_file null", 8'h00, {7'h0, flags_o.result_null});
    chk("complement_file done", 8'h01, {7'h0, exec_done_o});
    rd(8'h05, rv);
    chk("complement_file src", 8'h13, rv);
    wr(8'h7f, 8'hff);
    exec({OP_COMPLEMENT, 1'b1, 7'd127});
    chk("complement_file null2", 8'h01, {7'h0, flags_o.result_null});
    chk("complement_file acc2", 8'hec, accumulator_o);
    rd(8'h7f, rv);
    chk("complement_file file", 8'h00, rv);
  endtask
  // Decrement to zero, then wrap below zero into the file
  task automatic t_decrement;
    wr(8'h05, 8'h01);
    exec({OP_DECREMENT, 1'b0, 7'd5});
    chk("decrement_file acc", 8'h00, accumulator_o);
    chk("decrement_file null", 8'h01, {7'h0, flags_o.result_null});
    exec({OP_DECREMENT, 1'b1, 7'd6});
    chk("decrement_file wrap null", 8'h00, {7'h0, flags_o.result_null});
    chk("decrement_file acc kept", 8'h00, accumulator_o);
    rd(8'h06, rv);
    chk("decrement_file file", 8'hff, rv);
  endtask
  // Clear accumulator from a nonzero value with null flag low
  task automatic t_clear;
    wr(ADDR_ACCUM, 8'h5a);
    wr(ADDR_STATUS, 8'h06);
    exec(OP_CLEAR_WORKING);
    chk("clear_working acc", 8'h00, accumulator_o);
    chk("clear_working flags", 8'h07, {5'h0, flags_o});
    chk("clear_working done", 8'h01, {7'h0, exec_done_o});
  endtask
  // Kick after the counter has run; prescaler read right after
  task automatic t_kick;
    wr(ADDR_STATUS, 8'h01);
    repeat (300) @(posedge mclk_i);
    instr_i <= '{valid: 1'b1, word: OP_WATCHDOG_KICK};
    @(posedge mclk_i);
    instr_i <= '0;
    bus_i   <= '{wr: 1'b0, rd: 1'b1, addr: ADDR_PRESC, wdata: 8'h00};
    #1;
    chk("kick wdog", 8'h00, watchdog_count_o);
    chk("kick flags", 8'h07, {5'h0, flags_o});
    @(posedge mclk_i);
    bus_i <= '0;
    #1;
    chk("kick presc", 8'h00, rdata_o);
    rd(ADDR_STATUS, rv);
    chk("kick status", 8'h07, rv);
    rd(ADDR_WDOG, rv);
    chk("kick wdog rd", 8'h00, rv);
  endtask
  // Unknown word and unmapped read
  task automatic t_misc;
    exec(14'h3fff);
    chk("unk pulse", 8'h01, {7'h0, exec_unknown_o});
    chk("unk done", 8'h00, {7'h0, exec_done_o});
    rd(8'h90, rv);
    chk("unmapped", 8'h00, rv);
  endtask
  // Verdict
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    chk("rst flags", 8'h06, {5'h0, flags_o});
    t_complement();
    t_decrement();
    t_clear();
    t_kick();
    t_misc();
    final_report();
  end
endmodule // ccd_core_tb
`default_nettype wire
